// [pmv_pkg.sv]
package pmv_pkg;

    localparam int          PC_W         = 21;
    localparam int          SP_W         = 5;
    localparam int          STK_DEPTH    = 31;
    localparam int          WORD_W       = 16;
    localparam logic [20:0] RESET_VEC    = 21'h000000;
    localparam logic [20:0] HIGH_VEC     = 21'h000008;
    localparam logic [20:0] LOW_VEC      = 21'h000018;
    localparam logic [20:0] PC_STEP      = 21'h000002;
    localparam logic [4:0]  SP_RESET     = 5'h00;
    localparam logic [4:0]  SP_MAX       = 5'h1F;
    localparam int          MEM_BYTES_LG = 32768;
    localparam int          MEM_BYTES_SM = 16384;

    typedef enum logic [1:0]
    {
        PMV_RUN    = 2'b00,
        PMV_SLEEP  = 2'b01,
        PMV_VECTOR = 2'b11
    } pmv_state_t;

    typedef struct packed
    {
        logic        wake;
        logic        high_prio;
        logic        high_prio_global_irq_enable;
        logic        low_prio_global_irq_enable;
    } pmv_wake_t;

    typedef struct packed
    {
        logic        valid;
        logic [20:0] addr;
    } pmv_fetch_t;

endpackage

// [pmv_prog_mem.sv]
`timescale 1ns/1ps
module pmv_prog_mem
    import pmv_pkg::*;
#(
    parameter int MEM_BYTES = MEM_BYTES_LG
)
(
    input  wire logic                clk,
    input  wire logic [PC_W-1:0]     fetch_addr,
    input  wire logic                load_en,
    input  wire logic [PC_W-1:0]     load_addr,
    input  wire logic [WORD_W-1:0]   load_data,
    output logic      [WORD_W-1:0]   fetch_data
);
    localparam int WORDS = MEM_BYTES / 2;
    localparam int AW    = $clog2(WORDS);

    logic [WORD_W-1:0] mem [WORDS];
    logic              in_range;
    logic              load_in_range;

    // Beyond implemented memory reads zero
    assign in_range      = fetch_addr < PC_W'(MEM_BYTES);
    assign load_in_range = load_addr < PC_W'(MEM_BYTES);

    always_ff @(posedge clk)
    begin
        if (load_en && load_in_range)
        begin
            mem[load_addr[AW:1]] <= load_data;
        end
        fetch_data <= in_range ? mem[fetch_addr[AW:1]] : '0;
    end
endmodule // pmv_prog_mem

// [pmv_top.sv]
`timescale 1ns/1ps
// Operation
// - 21-bit program counter spans 2 Mbytes
// - Any reset starts fetch at 0000h
// - High vector 0008h, low vector 0018h
// - Reads above implemented memory return zero
// - Memory 32 or 16 Kbytes by variant
// - Separate program and data buses
// - Interrupt wake loads matching vector when its global enable is set
// - Interrupt wake pushes PC to stack when its global enable is set
// - Wake source recorded in flag bits
// - 31x21 stack, increment then write
// - Reset clears pointer; slot zero empty
module pmv_top
    import pmv_pkg::*;
#(
    parameter int MEM_BYTES = MEM_BYTES_LG
)
(
    input  wire logic                CLK,
    input  wire logic                NRST,
    input  wire logic                SLEEP_REQ,
    input  wire logic                ADVANCE,
    input  wire logic                JUMP,
    input  wire logic [PC_W-1:0]     JUMP_ADDR,
    input  wire pmv_wake_t           WAKE,
    input  wire logic                PROG_LOAD,
    input  wire logic [PC_W-1:0]     PROG_ADDR,
    input  wire logic [WORD_W-1:0]   PROG_DATA,
    input  wire logic                DATA_WE,
    input  wire logic [7:0]          DATA_ADDR,
    input  wire logic [7:0]          DATA_WDATA,
    output logic      [7:0]          DATA_RDATA,
    output pmv_fetch_t               FETCH,
    output logic      [WORD_W-1:0]   INSTR,
    output logic                     ASLEEP,
    output logic      [SP_W-1:0]     RETURN_STACK_POINTER,
    output logic      [PC_W-1:0]     TOP_OF_STACK,
    output logic      [1:0]          WAKE_FLAGS
);
    pmv_state_t        state_q, state_d;
    logic [PC_W-1:0]   pc_q, pc_d;
    logic [SP_W-1:0]   sp_q, sp_d;
    logic [1:0]        flags_q, flags_d;
    logic [PC_W-1:0]   stack [1:STK_DEPTH];
    logic              push;
    logic [7:0]        dmem [256];
    logic              vec_ok;
    // Registered top entry; combinational memory port controls
    logic [PC_W-1:0]   vec_addr;
    logic [SP_W-1:0]   sp_inc;
    logic [PC_W-1:0]   tos_q, tos_d;
    logic              stk_we;
    logic [SP_W-1:0]   stk_idx;
    logic [PC_W-1:0]   stk_wdata;
    logic              dat_we;
    logic [7:0]        dat_idx;
    logic [7:0]        dat_wdata;
    logic [7:0]        rdata_q, rdata_d;

    assign vec_ok = WAKE.high_prio ? WAKE.high_prio_global_irq_enable
                                   : WAKE.low_prio_global_irq_enable;

    // Vector from recorded source
    always_comb
    begin
        vec_addr = LOW_VEC;
        if (flags_q[1])
        begin
            vec_addr = HIGH_VEC;
        end
    end

    // Pointer saturates at last slot
    always_comb
    begin
        sp_inc = sp_q + 5'h01;
        if (sp_q == SP_MAX)
        begin
            sp_inc = SP_MAX;
        end
    end

    always_comb
    begin
        state_d = state_q;
        pc_d    = pc_q;
        sp_d    = sp_q;
        flags_d = flags_q;
        push    = 1'b0;
        case (state_q)
            PMV_RUN:
            begin
                if (SLEEP_REQ)
                begin
                    state_d = PMV_SLEEP;
                end
                else if (JUMP)
                begin
                    pc_d = JUMP_ADDR;
                end
                else if (ADVANCE)
                begin
                    pc_d = pc_q + PC_STEP;
                end
            end
            PMV_SLEEP:
            begin
                if (WAKE.wake)
                begin
                    flags_d = {WAKE.high_prio, ~WAKE.high_prio};
                    state_d = vec_ok ? PMV_VECTOR : PMV_RUN;
                end
            end
            PMV_VECTOR:
            begin
                push    = 1'b1;
                sp_d    = sp_inc;
                pc_d    = vec_addr;
                state_d = PMV_RUN;
            end
            default:
            begin
                state_d = PMV_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state_q <= PMV_RUN;
            pc_q    <= RESET_VEC;
            sp_q    <= SP_RESET;
            flags_q <= 2'h0;
        end
        else
        begin
            state_q <= state_d;
            pc_q    <= pc_d;
            sp_q    <= sp_d;
            flags_q <= flags_d;
        end
    end

    // Top entry kept in a register; follows pushes
    always_comb
    begin
        stk_we    = push;
        stk_idx   = sp_d;
        stk_wdata = pc_q;
        if (sp_d == SP_RESET)
        begin
            tos_d = '0;
        end
        else if (push)
        begin
            tos_d = pc_q;
        end
        else
        begin
            tos_d = stack[sp_d];
        end
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            tos_q <= '0;
        end
        else
        begin
            tos_q <= tos_d;
        end
    end

    // Write lands in incremented slot; slot zero unused
    always_ff @(posedge CLK)
    begin
        if (stk_we)
        begin
            stack[stk_idx] <= stk_wdata;
        end
    end

    // Independent data bus alongside fetch
    always_comb
    begin
        dat_we    = DATA_WE;
        dat_idx   = DATA_ADDR;
        dat_wdata = DATA_WDATA;
        rdata_d   = dmem[DATA_ADDR];
    end

    always_ff @(posedge CLK)
    begin
        if (dat_we)
        begin
            dmem[dat_idx] <= dat_wdata;
        end
        rdata_q <= rdata_d;
    end

    pmv_prog_mem #(
        .MEM_BYTES (MEM_BYTES)
    ) u_mem (
        .clk        (CLK),
        .fetch_addr (pc_q),
        .load_en    (PROG_LOAD),
        .load_addr  (PROG_ADDR),
        .load_data  (PROG_DATA),
        .fetch_data (INSTR)
    );

    assign FETCH.valid          = (state_q == PMV_RUN);
    assign FETCH.addr           = pc_q;
    assign ASLEEP               = (state_q == PMV_SLEEP);
    assign RETURN_STACK_POINTER = sp_q;
    assign TOP_OF_STACK         = tos_q;
    assign DATA_RDATA           = rdata_q;
    assign WAKE_FLAGS           = flags_q;
endmodule // pmv_top

// [pmv_top_properties.sv]
`timescale 1ns/1ps
module pmv_chk
    import pmv_pkg::*;
(
    input wire logic        CLK,
    input wire logic        NRST,
    input wire logic        SLEEP_REQ,
    input wire logic        ADVANCE,
    input wire logic        JUMP,
    input wire pmv_wake_t   WAKE,
    input wire pmv_fetch_t  FETCH,
    input wire logic        ASLEEP,
    input wire logic [4:0]  RETURN_STACK_POINTER,
    input wire logic [20:0] TOP_OF_STACK,
    input wire logic [1:0]  WAKE_FLAGS
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    wire [20:0] pc = FETCH.addr;
    wire [4:0]  sp = RETURN_STACK_POINTER;
    wire        run_step = FETCH.valid && ADVANCE && !JUMP && !SLEEP_REQ;
    wire        vec_take = ASLEEP && WAKE.wake
        && (WAKE.high_prio ? WAKE.high_prio_global_irq_enable : WAKE.low_prio_global_irq_enable);
    step_pc_a: assert property (run_step |=> pc == $past(pc) + PC_STEP) else $error("step");
    vec_load_a: assert property (vec_take |=> ##1 pc == ($past(WAKE.high_prio, 2) ? HIGH_VEC : LOW_VEC))
        else $error("vec");
    tos_push_a: assert property (vec_take |=> ##1 TOP_OF_STACK == $past(pc, 2)) else $error("tos");
    sp_push_a: assert property (vec_take && sp < SP_MAX |=> ##1 sp == $past(sp, 2) + 5'h01) else $error("sp");
    no_push_a: assert property (ASLEEP && WAKE.wake && !vec_take |=> ##1 sp == $past(sp, 2)) else $error("skip");
    wake_flag_a: assert property (ASLEEP && WAKE.wake |=> WAKE_FLAGS == ($past(WAKE.high_prio) ? 2'b10 : 2'b01))
        else $error("flag");
    slot_zero_a: assert property (sp == SP_RESET |-> TOP_OF_STACK == '0) else $error("slot");
    reset_pc_a: assert property ($rose(NRST) |-> pc == RESET_VEC && sp == SP_RESET) else $error("reset");
endmodule // pmv_chk
bind pmv_top pmv_chk u_pmv_chk (.*);

// [pmv_core_model.sv]
`timescale 1ns/1ps
module pmv_core_model
(
    input  wire logic clk,
    input  wire logic go,
    input  wire logic valid,
    output logic      advance = 1'b0
);
    // Step the fetch only while the block runs
    always @(negedge clk) advance <= go && valid;
endmodule // pmv_core_model

// [pmv_top_tb.sv]
`timescale 1ns/1ps
module pmv_top_tb import pmv_pkg::*;;
    logic        CLK = 1'b0;
    logic        NRST, SLEEP_REQ, ADVANCE, JUMP, PROG_LOAD, DATA_WE, ASLEEP, go, hp, en;
    logic [20:0] JUMP_ADDR, PROG_ADDR, TOP_OF_STACK, pc;
    logic [15:0] PROG_DATA, INSTR;
    logic [7:0]  DATA_ADDR, DATA_WDATA, DATA_RDATA;
    logic [4:0]  RETURN_STACK_POINTER, sp;
    logic [1:0]  WAKE_FLAGS;
    logic [31:0] rs = 32'h211C;
    pmv_wake_t   WAKE;
    pmv_fetch_t  FETCH;
    int          n_errors, total_checks;
    pmv_top #(.MEM_BYTES(MEM_BYTES_SM)) u_pmv_top (.*);
    pmv_core_model u_pmv_core_model (.clk(CLK), .go(go), .valid(FETCH.valid), .advance(ADVANCE));
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task chk(string n, logic [31:0] s, e);
        total_checks++;
        n_errors += int'(s !== e);
        if (s !== e)
            $display("wrong value %s exp %h seen %h", n, e, s);
    endtask
    task print_verdict;
        if (n_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial forever #25 CLK = ~CLK;
    initial
    begin
        rs = xs(rs);
        {NRST, SLEEP_REQ, JUMP, PROG_LOAD, DATA_WE, go, JUMP_ADDR, DATA_ADDR, DATA_WDATA, WAKE, sp} = '0;
        {PROG_ADDR, PROG_DATA} = {21'(MEM_BYTES_SM - 2), rs[15:0]};
        repeat (16) @(negedge CLK);
        {NRST, PROG_LOAD} = 2'b11;
        @(negedge CLK) {PROG_LOAD, JUMP, JUMP_ADDR} = {2'b01, PROG_ADDR};
        @(negedge CLK) {JUMP, DATA_WE, DATA_ADDR, DATA_WDATA} = {2'b01, rs[31:16]};
        go <= 1;
        @(negedge CLK) chk("ins", INSTR, PROG_DATA);
        DATA_WE = 0;
        @(negedge CLK) chk("dat", DATA_RDATA, rs[23:16]);
        for (int i = 0; i < 8 && FETCH.addr !== PROG_ADDR + 4; i++)
            @(negedge CLK);
        chk("pc", FETCH.addr, PROG_ADDR + 4);
        chk("zero", INSTR, 16'h0);
        go <= 0;
        for (int i = 0; i < 4; i++)
        begin
            rs = xs(rs);
            {hp, en, pc} = {i[0], i[1], rs[20:1], 1'b0};
            @(negedge CLK) {JUMP, JUMP_ADDR} = {1'b1, pc};
            @(negedge CLK) {JUMP, SLEEP_REQ} = 2'b01;
            @(negedge CLK) {SLEEP_REQ, WAKE} = {2'b01, hp, ~(hp ^ en), hp ^ en};
            chk("slp", ASLEEP, 1'b1);
            @(negedge CLK) WAKE = '0;
            @(negedge CLK) sp += en;
            chk("vec", FETCH.addr, en ? (hp ? HIGH_VEC : LOW_VEC) : pc);
            chk("sp", RETURN_STACK_POINTER, sp);
            chk("awk", ASLEEP, 1'b0);
            chk("flg", WAKE_FLAGS, {hp, ~hp});
            if (en) chk("tos", TOP_OF_STACK, pc);
        end
        NRST = 0;
        @(negedge CLK) NRST = 1;
        chk("rst", {FETCH.addr, RETURN_STACK_POINTER}, {RESET_VEC, SP_RESET});
        print_verdict;
    end
endmodule // pmv_top_tb
